// >>> include/dbp_pkg.sv
// constants for the dram byte parity logic
`default_nettype none
package dbp_pkg;
   localparam int DBP_DATA_W = 64;
   localparam int DBP_BYTES  = 8;
   localparam int DBP_BANKS  = 4;
   localparam logic [DBP_BYTES-1:0] DBP_PAR_RST  = 8'h00;
   localparam logic [DBP_BYTES-1:0] DBP_EXTRA_WR = 8'hff;
   localparam logic [DBP_DATA_W-1:0] DBP_DATA_RST = 64'h0000_0000_0000_0000;
endpackage
`default_nettype wire

// >>> core/dbp_parity_logic.sv
// byte parity generation, read check and sticky fault capture
//
// Overview of operation
// - one parity bit is kept per data byte, computed from that byte alone.
// - parity is odd: the bit is one when its byte holds an even count of ones.
// - parity is formed on every write so it is ready when the column strobes write.
// - the parity row strobe is asserted for any cycle aimed at any of the four banks.
// - the write data register is latched in the clock where next ready is asserted.
// - the write parity register latches one clock after the write data register.
// - the write parity latch comes from the rising system clock, ahead of column strobes.
// - extra generator inputs are held at one on writes and take read parity on reads.
// - read parity is latched by the read data latch strobe together with read data.
// - read parity register outputs are enabled only in reads by the direction control.
// - the check failure rises in a read when any byte mismatches its parity bit.
// - a raised fault is held in a register after the failing cycle ends.
// - the fault capture strobe pulses one clock after each read data latch strobe in a read.
// - a held fault may be cleared no earlier than the read after the failing one.
// - the read data latch strobe comes only after one added wait state.
`default_nettype none
module dbp_parity_logic
   import dbp_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // controller cycle status
   input  wire logic                   cyc_active,
   input  wire logic                   cyc_write,
   input  wire logic [DBP_BANKS-1:0]   bank_sel,
   input  wire logic                   next_ready_n,
   input  wire logic                   rd_data_arrive,
   input  wire logic                   fault_clear,
   // processor side data
   input  wire logic [DBP_DATA_W-1:0]  wr_data,
   output logic      [DBP_DATA_W-1:0]  rd_data_q,
   // dram side data
   input  wire logic [DBP_DATA_W-1:0]  dram_rd_data,
   input  wire logic [DBP_BYTES-1:0]   parity_dq_in,
   output logic      [DBP_BYTES-1:0]   parity_dq_out,
   output logic                        parity_dq_oe,
   // strobes
   output logic                        parity_row_strobe_n,
   output logic                        write_data_latch,
   output logic                        write_parity_latch,
   output logic                        read_data_latch,
   output logic                        memory_read_direction,
   output logic                        fault_capture_strobe,
   // check results
   output logic      [DBP_BYTES-1:0]   odd_check_output,
   output logic                        parity_check_fail,
   output logic                        parity_fault_flag
);

   // byte-wise odd parity: one when the byte has an even count of ones
   function automatic logic [DBP_BYTES-1:0] odd_par(input logic [DBP_DATA_W-1:0] d);
      logic [DBP_BYTES-1:0] p;
      p = '0;
      for (int i = 0; i < DBP_BYTES; i++) begin
         p[i] = ~^d[i*8 +: 8];
      end
      return p;
   endfunction

   logic [DBP_DATA_W-1:0] wr_data_q;
   logic [DBP_BYTES-1:0]  rd_par_q;
   logic                  rd_wait;
   logic                  cyc_read;
   logic [DBP_BYTES-1:0]  extra_in;
   logic [DBP_BYTES-1:0]  next_check;
   logic                  any_mismatch;
   logic                  next_fault;

   assign cyc_read              = cyc_active & ~cyc_write;
   assign memory_read_direction = cyc_read;
   assign parity_row_strobe_n   = ~(cyc_active & (|bank_sel));
   assign write_data_latch      = cyc_write & ~next_ready_n;
   assign parity_dq_oe          = cyc_write;

   // read parity register only reaches the generators while reading
   assign extra_in = memory_read_direction ? rd_par_q : DBP_EXTRA_WR;

   // check output high means the byte plus its stored bit is not odd
   genvar g;
   generate
      for (g = 0; g < DBP_BYTES; g++) begin : g_chk
         assign next_check[g] = ~^{rd_data_q[g*8 +: 8], extra_in[g]};
      end
   endgenerate
   assign odd_check_output  = next_check;
   assign any_mismatch      = |next_check;
   // only meaningful once the strobe marks a latched read
   assign parity_check_fail = fault_capture_strobe & cyc_read & any_mismatch;

   // set beats clear; a clear alone cannot hit the read that raised the fault
   assign next_fault = parity_check_fail ? 1'b1 :
                       (fault_capture_strobe & fault_clear) ? 1'b0 :
                       parity_fault_flag;

   // write path
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_data_q          <= DBP_DATA_RST;
         write_parity_latch <= 1'b0;
         parity_dq_out      <= DBP_PAR_RST;
      end else begin
         if (write_data_latch) begin
            wr_data_q <= wr_data;
         end
         // registered off the rising clock so parity settles before column strobes
         write_parity_latch <= write_data_latch;
         if (write_parity_latch) begin
            parity_dq_out <= odd_par(wr_data_q);
         end
      end
   end

   // read path
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_wait              <= 1'b0;
         read_data_latch      <= 1'b0;
         rd_data_q            <= DBP_DATA_RST;
         rd_par_q             <= DBP_PAR_RST;
         fault_capture_strobe <= 1'b0;
      end else begin
         rd_wait              <= cyc_read & rd_data_arrive;
         read_data_latch      <= rd_wait & cyc_read;
         fault_capture_strobe <= read_data_latch & cyc_read;
         if (read_data_latch) begin
            rd_data_q <= dram_rd_data;
            rd_par_q  <= parity_dq_in;
         end
      end
   end

   // sticky fault
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         parity_fault_flag <= 1'b0;
      end else begin
         parity_fault_flag <= next_fault;
      end
   end

endmodule
`default_nettype wire

// >>> verif/dbp_par_dram.sv
// parity dram model
`default_nettype none
module dbp_par_dram (
   // pins
   input wire logic       clk, write_parity_latch, parity_dq_oe,
   input wire logic [7:0] parity_dq_out,
   output logic     [7:0] parity_dq_in
);
   logic [7:0] mem;
   logic       wpl_d;
   always_ff @(posedge clk) begin
      wpl_d <= write_parity_latch;
      if (wpl_d) mem <= parity_dq_out;
   end
   // released in writes: never echo a settled value
   assign parity_dq_in = parity_dq_oe ? ~mem : mem;
endmodule
`default_nettype wire

// >>> verif/dbp_parity_sva.sv
// port assertions for the parity logic
`default_nettype none
module dbp_parity_sva (
   // status and strobes
   input wire logic       clk, sys_rst, cyc_active, cyc_write, next_ready_n, rd_data_arrive,
   input wire logic [3:0] bank_sel,
   input wire logic       write_data_latch, write_parity_latch, read_data_latch,
   input wire logic       memory_read_direction, fault_capture_strobe, parity_row_strobe_n,
   input wire logic       parity_check_fail, parity_fault_flag, parity_dq_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic rd = memory_read_direction;
   a_wdl_ready: assert property (cyc_write && !next_ready_n |-> write_data_latch)
      else $error("wdl");
   a_wpl_follow: assert property (write_data_latch |=> write_parity_latch) else $error("wpl");
   a_row_any: assert property (cyc_active && |bank_sel |-> !parity_row_strobe_n)
      else $error("row");
   a_rdl_wait: assert property (rd_data_arrive && rd ##1 rd ##1 rd |-> read_data_latch)
      else $error("rdl");
   a_cap_each: assert property (read_data_latch && rd ##1 rd |-> fault_capture_strobe)
      else $error("cap");
   a_fail_quiet: assert property (!rd |-> !parity_check_fail) else $error("fail");
   a_flag_set: assert property (parity_check_fail |=> parity_fault_flag) else $error("set");
   a_flag_hold: assert property (parity_fault_flag && !fault_capture_strobe |=> parity_fault_flag)
      else $error("hold");
   a_dir_write: assert property (cyc_write |-> !memory_read_direction)
      else $error("dir");
   a_oe_read: assert property (memory_read_direction |-> !parity_dq_oe)
      else $error("oe");
   a_row_idle: assert property (!cyc_active |-> parity_row_strobe_n)
      else $error("idle");
endmodule
bind dbp_parity_logic dbp_parity_sva chk_i (.*);
`default_nettype wire

// >>> verif/dbp_parity_logic_tb.sv
// bench for the byte parity logic
`default_nettype none
module dbp_parity_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, sys_rst = 1, cyc_active = 0, cyc_write = 0, next_ready_n = 1;
   logic        rd_data_arrive = 0, fault_clear = 0, parity_dq_oe, write_parity_latch;
   logic        parity_row_strobe_n, write_data_latch, read_data_latch, memory_read_direction;
   logic        fault_capture_strobe, parity_check_fail, parity_fault_flag;
   logic [3:0]  bank_sel = 4'h0;
   logic [63:0] wr_data = 64'h0, dram_rd_data = 64'h0, rd_data_q;
   logic [7:0]  parity_dq_in, parity_dq_out, odd_check_output;
   int          fails = 0, check_count = 0;
   dbp_parity_logic uut (.*);
   dbp_par_dram model (.*);
   initial forever #4 clk = ~clk;
   task automatic chk(input logic [63:0] s, e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // bytes hold 2,7,0,1,1,2,8,0 ones
   task automatic wr;
      @(posedge clk) {cyc_active, cyc_write, bank_sel, next_ready_n} <= 7'h62;
      wr_data <= 64'h00ff_0301_8000_7f11;
      @(posedge clk) next_ready_n <= 1;
      @(posedge clk) #1 chk(parity_dq_out, 8'he5);
      @(posedge clk) {cyc_active, cyc_write} <= 2'b00;
   endtask
   task automatic rd(input logic [3:0] b, input logic bad, clr, flag);
      @(posedge clk) {cyc_active, cyc_write, bank_sel, rd_data_arrive} <= {2'b10, b, 1'b1};
      fault_clear <= clr;
      dram_rd_data <= 64'h00ff_0301_8000_7f11 ^ {63'h0, bad};
      @(posedge clk) rd_data_arrive <= 0;
      repeat (2) @(posedge clk);
      #1 chk(parity_check_fail, bad);
      chk(odd_check_output, {7'h00, bad});
      chk(rd_data_q, dram_rd_data);
      @(posedge clk) #1 chk(parity_fault_flag, flag);
      cyc_active <= 0;
   endtask
   task automatic stop_test;
      $display("fails %0d checks %0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk) #1 chk(parity_fault_flag, 0);
      wr;
      rd(4'h1, 0, 0, 0);
      rd(4'h2, 1, 1, 1);
      wr;
      #1 chk(parity_fault_flag, 1);
      rd(4'h4, 0, 1, 0);
      rd(4'h8, 0, 0, 0);
      stop_test;
   end
   initial begin
      #100000;
      fails++;
      stop_test;
   end
endmodule
`default_nettype wire
